/* File: core/xfcm_fifo.sv */
`timescale 1ns/1ns
module xfcm_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	xfcm_stream_if.receiver wr,
	xfcm_stream_if.sender rd
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two of at least two");
	end
	if (WIDTH < 1) begin : g_bad_width
		$error("fifo width must be positive");
	end
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} xfcm_fifo_s;
	xfcm_fifo_s s_q;
	xfcm_fifo_s s_d;
	logic full;
	logic empty;
	assign full = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
	assign empty = (s_q.wp == s_q.rp);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data = s_q.mem[s_q.rp[AW-1:0]];
	always_comb begin
		s_d = s_q;
		if (wr.valid && !full) begin
			s_d.mem[s_q.wp[AW-1:0]] = wr.data;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (rd.ready && !empty) begin
			s_d.rp = s_q.rp + 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : xfcm_fifo

/* File: core/xfcm_pkg.sv */
package xfcm_pkg;
	localparam int LANES = 4;
	localparam int WORD_W = 36;
	localparam int FIFO_DEPTH = 8;
	// xgmii control characters
	localparam logic [7:0] CHAR_IDLE = 8'h07;
	localparam logic [7:0] CHAR_SEQ = 8'h9c;
	localparam logic [7:0] CHAR_START = 8'hfb;
	localparam logic [7:0] CHAR_TERM = 8'hfd;
	localparam logic [7:0] CHAR_ERR = 8'hfe;
	// lane control codegroups
	localparam logic [7:0] K_SYNC = 8'hbc;
	localparam logic [7:0] K_SKIP = 8'h1c;
	localparam logic [7:0] K_ALIGN = 8'h7c;
	localparam logic [7:0] K_SEQ = 8'h9c;
	localparam logic [7:0] K_START = 8'hfb;
	localparam logic [7:0] K_TERM = 8'hfd;
	localparam logic [7:0] K_ERR = 8'hfe;
	// fault ordered-set type byte in lane 3, fill byte in lanes 1 and 2
	localparam logic [7:0] FAULT_LOCAL = 8'h01;
	localparam logic [7:0] FAULT_REMOTE = 8'h02;
	localparam logic [7:0] FAULT_FILL = 8'h00;
	// idle generation
	localparam logic [6:0] LFSR_SEED = 7'h7f;
	localparam logic [4:0] ALIGN_MIN = 5'h0f;
	// lane sync and gap checks
	localparam logic [2:0] COMMA_NEED = 3'h4;
	localparam logic [2:0] ERR_LIMIT = 3'h4;
	localparam logic [2:0] IFG_SHORT_MAX = 3'h3;
	localparam logic [2:0] IFG_SAT = 3'h7;
	// status vector bit positions
	localparam int ST_TX_FAULT = 0;
	localparam int ST_RX_FAULT = 1;
	localparam int ST_SYNC_LO = 2;
	localparam int ST_ALIGN = 6;
	localparam int ST_LINK = 7;
	// diagnostic bit positions
	localparam int DBG_UP = 0;
	localparam int DBG_SYNC_LO = 1;
	localparam int DBG_ALIGN = 5;
	typedef enum logic {ALIGN_LOST, ALIGN_DONE} xfcm_align_e;
endpackage : xfcm_pkg

/* File: core/xfcm_stream_if.sv */
`timescale 1ns/1ns
interface xfcm_stream_if #(parameter int W = 36);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport sender (output valid, output data, input ready);
	modport receiver (input valid, input data, output ready);
endinterface : xfcm_stream_if

/* File: core/xfcm_top.sv */
`timescale 1ns/1ns
// Contract
// [R1] ctrl flag 0 data; 07 9c fb fd fe
// [R2] lane codes bc 1c 7c 9c fb fd fe
// [R3] idle columns become randomized sync/skip/align
// [R4] fault messages start 9c control lane 0
// [R5] fault and link status latch until cleared
// [R6] receiver not up sends local fault
// [R7] receive fault shown in status vector
// [R8] six-bit live sync and align diagnostics
// [R9] transmit fault while transmitter reset or uninitialized
// [R10] only mac originates remote fault messages
// [R11] mac sends idles on remote fault
// [R12] mac sends remote fault on local fault
// [R13] received remote fault passed through unchanged
// [R14] eight-bit link status vector exposed
// [R15] short gap puts fe before terminate
// [R16] bad codegroups become fe control bytes
// [R17] no signal detect holds lane unsynced
// [R18] alignment dropped on invalid or partial align
// [R19] fault type byte distinguishes local remote
module xfcm_top #(
	parameter int FIFO_DEPTH = xfcm_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [31:0] txData,
	input wire logic [3:0] txCtrl,
	input wire logic txValid,
	output logic txReady,
	output logic [31:0] laneTxData,
	output logic [3:0] laneTxIsK,
	output logic laneTxValid,
	input wire logic laneTxReady,
	input wire logic [31:0] laneRxData,
	input wire logic [3:0] laneRxIsK,
	input wire logic [3:0] laneRxCodeValid,
	input wire logic [3:0] signalDetect,
	input wire logic rxLocked,
	input wire logic rxInReset,
	input wire logic txInReset,
	input wire logic txInitDone,
	input wire logic clearLocalFault,
	input wire logic clearLinkStatus,
	output logic [31:0] rxData,
	output logic [3:0] rxCtrl,
	output logic [7:0] statusVector,
	output logic [5:0] debug
);
	localparam int L = xfcm_pkg::LANES;
	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("fifo depth too small");
	end
	typedef struct packed {
		logic [6:0] lfsr;
		logic [4:0] alignCnt;
		logic [35:0] txOut;
		logic txOutValid;
		logic [3:0][2:0] commaCnt;
		logic [3:0][2:0] errCnt;
		logic [3:0] sync;
		xfcm_pkg::xfcm_align_e align;
		logic gapActive;
		logic [2:0] idleCnt;
		logic shortIfg;
		logic [35:0] pipe;
		logic [35:0] rxOut;
		logic rxFault;
		logic txFault;
		logic link;
	} xfcm_state_s;
	localparam xfcm_state_s RST = '{
		lfsr: xfcm_pkg::LFSR_SEED,
		alignCnt: xfcm_pkg::ALIGN_MIN,
		align: xfcm_pkg::ALIGN_LOST,
		default: '0
	};
	xfcm_state_s s_q;
	xfcm_state_s s_d;
	xfcm_stream_if #(.W(xfcm_pkg::WORD_W)) txIn ();
	xfcm_stream_if #(.W(xfcm_pkg::WORD_W)) txBuf ();
	assign txIn.valid = txValid;
	assign txIn.data = {txCtrl, txData};
	assign txReady = txIn.ready;
	xfcm_fifo #(.WIDTH(xfcm_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.wr(txIn),
		.rd(txBuf)
	);
	assign txBuf.ready = !s_q.txOutValid || laneTxReady;
	assign laneTxData = s_q.txOut[31:0];
	assign laneTxIsK = s_q.txOut[35:32];
	assign laneTxValid = s_q.txOutValid;
	assign rxData = s_q.rxOut[31:0];
	assign rxCtrl = s_q.rxOut[35:32];
	logic rxUp;
	logic txLive;
	assign rxUp = rxLocked && !rxInReset && (&s_q.sync) && (s_q.align == xfcm_pkg::ALIGN_DONE); // [R6]
	assign txLive = txInReset || !txInitDone; // [R9]
	always_comb begin
		statusVector = '0;
		statusVector[xfcm_pkg::ST_TX_FAULT] = s_q.txFault; // [R9]
		statusVector[xfcm_pkg::ST_RX_FAULT] = s_q.rxFault; // [R7]
		statusVector[xfcm_pkg::ST_SYNC_LO +: 4] = s_q.sync; // [R14]
		statusVector[xfcm_pkg::ST_ALIGN] = (s_q.align == xfcm_pkg::ALIGN_DONE);
		statusVector[xfcm_pkg::ST_LINK] = s_q.link;
		debug = '0;
		debug[xfcm_pkg::DBG_UP] = rxUp;
		debug[xfcm_pkg::DBG_SYNC_LO +: 4] = s_q.sync; // [R8]
		debug[xfcm_pkg::DBG_ALIGN] = (s_q.align == xfcm_pkg::ALIGN_DONE); // [R8]
	end
	always_comb begin
		logic [31:0] td;
		logic [3:0] tc;
		logic [35:0] enc;
		logic allIdle;
		logic [7:0] idleCode;
		logic [35:0] dec;
		logic [35:0] prev;
		logic [35:0] fault;
		logic [7:0] rb;
		logic allA;
		logic anyA;
		logic anyBad;
		logic gap;
		logic sh;
		logic fixPrev;
		logic [2:0] cnt;
		s_d = s_q;
		td = txBuf.data[31:0];
		tc = txBuf.data[35:32];
		enc = '0;
		allIdle = 1'b1;
		idleCode = xfcm_pkg::K_SYNC;
		dec = '0;
		prev = s_q.pipe;
		fault = '0;
		rb = '0;
		allA = 1'b1;
		anyA = 1'b0;
		anyBad = 1'b0;
		gap = s_q.gapActive;
		sh = s_q.shortIfg;
		fixPrev = 1'b0;
		cnt = s_q.idleCnt;
		// transmit encoder
		for (int i = 0; i < L; i++) begin
			if (!(tc[i] && td[8*i +: 8] == xfcm_pkg::CHAR_IDLE)) begin
				allIdle = 1'b0;
			end
		end
		if (txBuf.valid && txBuf.ready) begin
			if (allIdle) begin
				if (s_q.alignCnt == '0) begin
					idleCode = xfcm_pkg::K_ALIGN; // [R3]
					s_d.alignCnt = xfcm_pkg::ALIGN_MIN + {1'b0, s_q.lfsr[3:0]}; // [R3]
				end else begin
					idleCode = s_q.lfsr[0] ? xfcm_pkg::K_SYNC : xfcm_pkg::K_SKIP; // [R3]
					s_d.alignCnt = s_q.alignCnt - 5'h01;
				end
				s_d.lfsr = {s_q.lfsr[5:0], s_q.lfsr[6] ^ s_q.lfsr[5]}; // [R3]
			end
			for (int i = 0; i < L; i++) begin
				enc[32 + i] = tc[i]; // [R1]
				enc[8*i +: 8] = td[8*i +: 8]; // [R1]
				if (tc[i]) begin
					case (td[8*i +: 8])
						xfcm_pkg::CHAR_IDLE: enc[8*i +: 8] = idleCode; // [R2]
						xfcm_pkg::CHAR_SEQ: enc[8*i +: 8] = xfcm_pkg::K_SEQ; // [R2]
						xfcm_pkg::CHAR_START: enc[8*i +: 8] = xfcm_pkg::K_START; // [R2]
						xfcm_pkg::CHAR_TERM: enc[8*i +: 8] = xfcm_pkg::K_TERM; // [R2]
						default: enc[8*i +: 8] = xfcm_pkg::K_ERR; // [R2]
					endcase
				end
			end
			s_d.txOut = enc;
			s_d.txOutValid = 1'b1;
		end else if (laneTxReady) begin
			s_d.txOutValid = 1'b0;
		end
		// lane synchronisation
		for (int i = 0; i < L; i++) begin
			if (!signalDetect[i]) begin
				s_d.sync[i] = 1'b0; // [R17]
				s_d.commaCnt[i] = '0; // [R17]
				s_d.errCnt[i] = '0;
			end else if (!s_q.sync[i]) begin
				if (!laneRxCodeValid[i]) begin
					s_d.commaCnt[i] = '0;
				end else if (laneRxIsK[i] && laneRxData[8*i +: 8] == xfcm_pkg::K_SYNC) begin
					s_d.commaCnt[i] = s_q.commaCnt[i] + 3'h1;
					if (s_q.commaCnt[i] == xfcm_pkg::COMMA_NEED - 3'h1) begin
						s_d.sync[i] = 1'b1;
						s_d.commaCnt[i] = '0;
					end
				end
			end else if (!laneRxCodeValid[i]) begin
				s_d.errCnt[i] = s_q.errCnt[i] + 3'h1;
				if (s_q.errCnt[i] == xfcm_pkg::ERR_LIMIT - 3'h1) begin
					s_d.sync[i] = 1'b0;
					s_d.errCnt[i] = '0;
				end
			end else begin
				s_d.errCnt[i] = '0;
			end
		end
		// lane alignment
		for (int i = 0; i < L; i++) begin
			if (laneRxCodeValid[i] && laneRxIsK[i] && laneRxData[8*i +: 8] == xfcm_pkg::K_ALIGN) begin
				anyA = 1'b1;
			end else begin
				allA = 1'b0;
			end
			if (!laneRxCodeValid[i]) begin
				anyBad = 1'b1;
			end
		end
		if (!(&s_q.sync)) begin
			s_d.align = xfcm_pkg::ALIGN_LOST;
		end else begin
			case (s_q.align)
				xfcm_pkg::ALIGN_LOST: if (allA && !anyBad) s_d.align = xfcm_pkg::ALIGN_DONE;
				xfcm_pkg::ALIGN_DONE: if (anyBad || (anyA && !allA)) s_d.align = xfcm_pkg::ALIGN_LOST; // [R18]
				default: s_d.align = xfcm_pkg::ALIGN_LOST;
			endcase
		end
		// receive decoder
		for (int i = 0; i < L; i++) begin
			rb = laneRxData[8*i +: 8];
			dec[8*i +: 8] = rb;
			dec[32 + i] = laneRxIsK[i];
			if (!laneRxCodeValid[i]) begin
				dec[8*i +: 8] = xfcm_pkg::CHAR_ERR; // [R16]
				dec[32 + i] = 1'b1; // [R16]
			end else if (laneRxIsK[i]) begin
				case (rb)
					xfcm_pkg::K_SYNC, xfcm_pkg::K_SKIP, xfcm_pkg::K_ALIGN:
						dec[8*i +: 8] = xfcm_pkg::CHAR_IDLE;
					xfcm_pkg::K_SEQ: dec[8*i +: 8] = xfcm_pkg::CHAR_SEQ; // [R13]
					xfcm_pkg::K_START: dec[8*i +: 8] = xfcm_pkg::CHAR_START;
					xfcm_pkg::K_TERM: dec[8*i +: 8] = xfcm_pkg::CHAR_TERM;
					default: dec[8*i +: 8] = xfcm_pkg::CHAR_ERR; // [R16]
				endcase
			end
		end
		// interframe gap check
		for (int i = 0; i < L; i++) begin
			if (dec[32 + i] && dec[8*i +: 8] == xfcm_pkg::CHAR_TERM) begin
				if (sh) begin
					if (i == 0) begin
						fixPrev = 1'b1; // [R15]
					end else begin
						dec[8*(i-1) +: 8] = xfcm_pkg::CHAR_ERR; // [R15]
						dec[32 + i - 1] = 1'b1; // [R15]
					end
				end
				sh = 1'b0;
				gap = 1'b1;
				cnt = '0;
			end else if (dec[32 + i] && dec[8*i +: 8] == xfcm_pkg::CHAR_START) begin
				sh = gap && (cnt <= xfcm_pkg::IFG_SHORT_MAX); // [R15]
				gap = 1'b0;
			end else if (gap && dec[32 + i] && dec[8*i +: 8] == xfcm_pkg::CHAR_IDLE) begin
				if (cnt != xfcm_pkg::IFG_SAT) begin
					cnt = cnt + 3'h1;
				end
			end
		end
		if (fixPrev) begin
			prev[31:24] = xfcm_pkg::CHAR_ERR; // [R15]
			prev[35] = 1'b1; // [R15]
		end
		// local fault ordered set
		fault[7:0] = xfcm_pkg::CHAR_SEQ; // [R4]
		fault[15:8] = xfcm_pkg::FAULT_FILL; // [R19]
		fault[23:16] = xfcm_pkg::FAULT_FILL; // [R19]
		fault[31:24] = xfcm_pkg::FAULT_LOCAL; // [R19]
		fault[35:32] = 4'h1; // [R4]
		if (rxUp) begin
			s_d.pipe = dec; // [R13]
			s_d.rxOut = prev;
			s_d.gapActive = gap;
			s_d.idleCnt = cnt;
			s_d.shortIfg = sh;
		end else begin
			s_d.pipe = fault; // [R6]
			s_d.rxOut = fault; // [R6]
			s_d.gapActive = 1'b0;
			s_d.idleCnt = '0;
			s_d.shortIfg = 1'b0;
		end
		// latched indications, the event wins over the clear
		s_d.rxFault = !rxUp || (s_q.rxFault && !clearLocalFault); // [R5]
		s_d.txFault = txLive || (s_q.txFault && !clearLocalFault); // [R5]
		s_d.link = rxUp && (s_q.link || clearLinkStatus); // [R5]
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_q <= RST;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : xfcm_top

/* File: test/xfcm_mac_model.sv */
`timescale 1ns/1ns
module xfcm_mac_model (
	input wire logic [31:0] rxData,
	input wire logic [3:0] rxCtrl,
	input wire logic [31:0] usrData,
	input wire logic [3:0] usrCtrl,
	input wire logic usrValid,
	output logic [31:0] txData,
	output logic [3:0] txCtrl,
	output logic txValid
);
	logic isSeq;
	logic gotLf;
	logic gotRf;
	assign isSeq = rxCtrl[0] && rxData[7:0] == 8'h9c;
	assign gotLf = isSeq && rxData[31:24] == 8'h01;
	assign gotRf = isSeq && rxData[31:24] == 8'h02;
	// frames dropped while a fault is seen
	assign txData = gotLf ? 32'h0200009c : gotRf ? 32'h07070707 : usrData;
	assign txCtrl = gotLf ? 4'h1 : gotRf ? 4'hf : usrCtrl;
	assign txValid = gotLf || gotRf || usrValid;
endmodule : xfcm_mac_model

/* File: test/xfcm_top_properties.sv */
`timescale 1ns/1ns
module xfcm_top_properties (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [31:0] rxData,
	input wire logic [3:0] rxCtrl,
	input wire logic [7:0] statusVector,
	input wire logic [5:0] debug,
	input wire logic [3:0] signalDetect,
	input wire logic [3:0] laneRxCodeValid,
	input wire logic clearLocalFault,
	input wire logic txInReset,
	input wire logic txInitDone,
	input wire logic rxLocked,
	input wire logic rxInReset,
	input wire logic laneTxValid,
	input wire logic laneTxReady
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_rxf; !debug[0] |=> statusVector[1]; endproperty
	a_rxf: assert property (p_rxf) else $error("rx fault not shown");
	property p_keep; statusVector[1] && !clearLocalFault |=> statusVector[1]; endproperty
	a_keep: assert property (p_keep) else $error("rx fault not held");
	property p_lf; !debug[0] |=> rxData == 32'h0100009c && rxCtrl == 4'h1; endproperty
	a_lf: assert property (p_lf) else $error("no local fault column");
	property p_txf; txInReset || !txInitDone |=> statusVector[0]; endproperty
	a_txf: assert property (p_txf) else $error("tx fault not shown");
	property p_live; statusVector[6:2] == debug[5:1]; endproperty
	a_live: assert property (p_live) else $error("live bits differ");
	property p_sd; !signalDetect[0] |=> !debug[1]; endproperty
	a_sd: assert property (p_sd) else $error("lane kept sync");
	property p_link; !debug[0] |=> !statusVector[7]; endproperty
	a_link: assert property (p_link) else $error("link up while down");
	property p_up; debug[0] |-> debug[5] && debug[4:1] == 4'hf && rxLocked && !rxInReset; endproperty
	a_up: assert property (p_up) else $error("up while not ready");
	property p_algn; debug[5] && laneRxCodeValid != 4'hf |=> !debug[5]; endproperty
	a_algn: assert property (p_algn) else $error("align kept");
	c_algn: cover property (debug[5]);
	c_link: cover property (statusVector[7]);
	c_stall: cover property (laneTxValid && !laneTxReady);
endmodule : xfcm_top_properties
bind xfcm_top xfcm_top_properties u_props (.clk, .reset_n, .rxData, .rxCtrl, .statusVector,
	.debug, .signalDetect, .laneRxCodeValid, .clearLocalFault, .txInReset, .txInitDone,
	.rxLocked, .rxInReset, .laneTxValid, .laneTxReady);

/* File: test/xfcm_top_tb.sv */
`timescale 1ns/1ns
module xfcm_top_tb;
	logic clk, reset_n, txValid, txReady, laneTxValid, laneTxReady, usrValid;
	logic rxLocked, rxInReset, txInReset, txInitDone, clearLocalFault, clearLinkStatus;
	logic [31:0] txData, usrData, laneTxData, laneRxData, rxData, d;
	logic [3:0] txCtrl, usrCtrl, laneTxIsK, laneRxIsK, laneRxCodeValid, signalDetect, rxCtrl;
	logic [7:0] statusVector;
	logic [5:0] debug;
	int n_errors, comparisons, seed, n, m;
	xfcm_top dut (.clk, .reset_n, .txData, .txCtrl, .txValid, .txReady, .laneTxData,
		.laneTxIsK, .laneTxValid, .laneTxReady, .laneRxData, .laneRxIsK, .laneRxCodeValid,
		.signalDetect, .rxLocked, .rxInReset, .txInReset, .txInitDone, .clearLocalFault,
		.clearLinkStatus, .rxData, .rxCtrl, .statusVector, .debug);
	xfcm_mac_model mac (.rxData, .rxCtrl, .usrData, .usrCtrl, .usrValid, .txData, .txCtrl,
		.txValid);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask : cyc
	task rxcol(input logic [31:0] dd, input logic [3:0] kk);
		laneRxData = dd;
		laneRxIsK = kk;
		cyc(1);
	endtask : rxcol
	task waitrx(input logic [31:0] dd, input logic [3:0] kk);
		for (int i = 0; i < 5 && !(rxData === dd && rxCtrl === kk); i++) cyc(1);
		chk("rxData", rxData, dd);
		chk("rxCtrl", 32'(rxCtrl), 32'(kk));
	endtask : waitrx
	task align;
		repeat (5) rxcol(32'hbcbcbcbc, 4'hf);
		rxcol(32'h7c7c7c7c, 4'hf);
		repeat (2) rxcol(32'hbcbcbcbc, 4'hf);
	endtask : align
	function automatic logic [31:0] exp_tx(input logic [31:0] dd, input logic [3:0] cc);
		logic [31:0] r;
		logic [7:0] b;
		r = dd;
		for (int i = 0; i < 4; i++) begin
			b = dd[8*i+:8];
			if (cc[i] && b == 8'h07) r[8*i+:8] = 8'hbc;
			else if (cc[i] && b != 8'h9c && b != 8'hfb && b != 8'hfd) r[8*i+:8] = 8'hfe;
		end
		return r;
	endfunction : exp_tx
	task send(input logic [31:0] dd, input logic [3:0] cc);
		usrData = dd;
		usrCtrl = cc;
		usrValid = 1'b1;
		for (int i = 0; i < 20 && txReady !== 1'b1; i++) cyc(1);
		cyc(1);
		usrValid = 1'b0;
		for (int i = 0; i < 20 && laneTxValid !== 1'b1; i++) cyc(1);
		chk("laneTxData", laneTxData, exp_tx(dd, cc));
		chk("laneTxIsK", 32'(laneTxIsK), 32'(cc));
	endtask : send
	initial begin
		#1000000;
		n_errors++;
		end_sim();
	end
	initial begin
		seed = 32'h5c6f7ca4;
		n_errors = 0;
		comparisons = 0;
		reset_n = 1'b0;
		usrValid = 1'b0;
		usrData = 32'h0;
		usrCtrl = 4'h0;
		laneTxReady = 1'b1;
		laneRxData = 32'h0;
		laneRxIsK = 4'h0;
		laneRxCodeValid = 4'hf;
		signalDetect = 4'hf;
		rxLocked = 1'b1;
		rxInReset = 1'b0;
		txInReset = 1'b1;
		txInitDone = 1'b0;
		clearLocalFault = 1'b0;
		clearLinkStatus = 1'b0;
		cyc(4);
		reset_n = 1'b1;
		cyc(8);
		chk("rxData", rxData, 32'h0100009c);
		chk("status", 32'(statusVector[1:0]), 32'h3);
		chk("laneTxData", laneTxData, 32'h0200009c);
		$display("test fault done");
		txInReset = 1'b0;
		txInitDone = 1'b1;
		align();
		chk("debug", 32'(debug), 32'h3f);
		chk("latched", 32'(statusVector[1]), 32'h1);
		clearLocalFault = 1'b1;
		clearLinkStatus = 1'b1;
		cyc(1);
		clearLocalFault = 1'b0;
		clearLinkStatus = 1'b0;
		cyc(1);
		chk("status", 32'(statusVector), 32'hfc);
		$display("test bring-up done");
		repeat (6) begin
			d = $random(seed);
			rxcol(d, 4'h0);
			waitrx(d, 4'h0);
		end
		rxcol(32'hbcbcbcfd, 4'hf);
		rxcol(32'h332211fb, 4'h1);
		rxcol(32'hfd665544, 4'h8);
		waitrx(32'hfdfe5544, 4'hc);
		rxcol(32'hbcbc27bc, 4'hf);
		waitrx(32'h0707fe07, 4'hf);
		$display("test receive done");
		laneRxCodeValid = 4'hb;
		rxcol(32'hbcbcbcbc, 4'hf);
		laneRxCodeValid = 4'hf;
		chk("aligned", 32'(debug[5]), 32'h0);
		waitrx(32'h0100009c, 4'h1);
		chk("link", 32'(statusVector[7]), 32'h0);
		signalDetect = 4'he;
		cyc(1);
		chk("sync0", 32'(debug[1]), 32'h0);
		signalDetect = 4'hf;
		align();
		rxcol(32'h0200009c, 4'h1);
		waitrx(32'h0200009c, 4'h1);
		cyc(6);
		chk("idleK", 32'(laneTxIsK), 32'hf);
		d = laneTxData;
		chk("idle", 32'(d[7:0] inside {8'hbc, 8'h1c, 8'h7c} && d == {4{d[7:0]}}), 32'h1);
		rxcol(32'hbcbcbcbc, 4'hf);
		cyc(8);
		$display("test remote fault done");
		repeat (4) begin
			d = $random(seed);
			send(d, 4'h0);
		end
		send(32'h559cfdfb, 4'hf);
		send(32'hfe07a5c3, 4'hc);
		$display("test transmit done");
		laneTxReady = 1'b0;
		usrValid = 1'b1;
		n = 0;
		repeat (12) begin
			if (txReady === 1'b1) n++;
			cyc(1);
		end
		chk("refused", 32'(txReady), 32'h0);
		chk("filled", 32'(n), 32'(xfcm_pkg::FIFO_DEPTH));
		usrValid = 1'b0;
		laneTxReady = 1'b1;
		m = 0;
		repeat (16) begin
			if (laneTxValid === 1'b1) m++;
			cyc(1);
		end
		chk("drained", 32'(m), 32'(n + 1));
		$display("test buffer done");
		clearLocalFault = 1'b1;
		cyc(1);
		clearLocalFault = 1'b0;
		cyc(1);
		chk("cleared", 32'(statusVector[1:0]), 32'h0);
		rxLocked = 1'b0;
		cyc(1);
		chk("up", 32'(debug[0]), 32'h0);
		waitrx(32'h0100009c, 4'h1);
		chk("rxFault", 32'(statusVector[1]), 32'h1);
		rxLocked = 1'b1;
		cyc(3);
		chk("recovered", 32'(debug[0]), 32'h1);
		rxInReset = 1'b1;
		waitrx(32'h0100009c, 4'h1);
		chk("up", 32'(debug[0]), 32'h0);
		rxInReset = 1'b0;
		$display("test receiver lock done");
		end_sim();
	end
endmodule : xfcm_top_tb
